// File: rtl/fplc_pkg.sv
// shared constants and types for the format parameter list checker
package fplc_pkg;

	// cdb protection selector codes
	localparam logic [1:0] SEL_TYPE0   = 2'h0;
	localparam logic [1:0] SEL_BAD_CDB = 2'h1;
	localparam logic [1:0] SEL_TYPE1   = 2'h2;
	localparam logic [1:0] SEL_TYPE2   = 2'h3;
	// header protection field usage codes
	localparam logic [2:0] USE_NONE    = 3'h0;
	localparam logic [2:0] USE_TYPE3   = 3'h1;

	// header byte 1 bit positions
	localparam int OPT_VALID_BIT   = 7;
	localparam int PRIM_DIS_BIT    = 6;
	localparam int CERT_DIS_BIT    = 5;
	localparam int HALT_BIT        = 4;
	localparam int PAT_INCL_BIT    = 3;
	localparam int IMMED_BIT       = 1;
	// pattern descriptor byte 0 fields
	localparam int PAT_MOD_HI      = 7;
	localparam int PAT_MOD_LO      = 6;
	localparam int SEC_INIT_BIT    = 5;

	// defaults taken when options_valid is clear
	localparam logic DEF_PRIM_DIS  = 1'b0;
	localparam logic DEF_CERT_DIS  = 1'b1;
	localparam logic DEF_HALT      = 1'b1;
	localparam logic DEF_PAT_INCL  = 1'b0;
	localparam logic DEF_SAVE_DIS  = 1'b1;

	// defect list forms
	localparam logic [2:0] LIST_BLOCK  = 3'h0;
	localparam logic [2:0] LIST_BFI    = 3'h4;
	localparam logic [2:0] LIST_PHYS   = 3'h5;
	localparam logic [15:0] MAX_DESC   = 16'h0400;
	localparam logic [3:0] BLK_DESC_B  = 4'h4;
	localparam logic [3:0] LONG_DESC_B = 4'h8;

	// protection trailer
	localparam logic [15:0] PI_EXTRA   = 16'h0008;
	localparam logic [63:0] PI_FILL    = 64'hFFFFFFFFFFFFFFFF;

	// sense keys and additional sense codes
	localparam logic [3:0] SK_NONE     = 4'h0;
	localparam logic [3:0] SK_MEDIUM   = 4'h3;
	localparam logic [3:0] SK_ILLEGAL  = 4'h5;
	localparam logic [15:0] ASC_NONE       = 16'h0000;
	localparam logic [15:0] ASC_BAD_CDB    = 16'h2400;
	localparam logic [15:0] ASC_BAD_PARAM  = 16'h2600;
	localparam logic [15:0] ASC_LIST_MISS  = 16'h1901;
	localparam logic [15:0] ASC_LIST_ERR   = 16'h1900;

	typedef enum logic [1:0] {
		FPLC_PROT0 = 2'h0,
		FPLC_PROT1 = 2'h1,
		FPLC_PROT2 = 2'h2
	} fplc_prot_t;

	typedef struct packed {
		logic [1:0]  cdb_protection_selector;
		logic [2:0]  usage;
		logic        options_valid;
		logic        primary_list_disable;
		logic        certify_disable;
		logic        halt_on_list_error;
		logic        pattern_included;
		logic        save_disable;
		logic        immed;
		logic        data_out;
		logic        page_certify_bit;
		logic [7:0]  pat_desc0;
		logic [7:0]  pat_type;
		logic [15:0] pat_len;
		logic [2:0]  list_form;
		logic [15:0] list_len;
		logic [15:0] block_len;
		logic [31:0] cmd_lba;
		logic [31:0] exp_ref_tag;
	} fplc_cmd_t;

endpackage

// File: rtl/fplc_if.sv
// link between initiator end and target checker end
`timescale 1ns/1ps
interface fplc_if;
	import fplc_pkg::*;
	logic        req;
	fplc_cmd_t   cmd;
	logic        ack;
	logic        done;
	logic        check_cond;
	logic        deferred;
	logic [3:0]  sense_key;
	logic [15:0] asc;
	logic        app_tag_owner;

	modport target (
		input  req, cmd,
		output ack, done, check_cond, deferred, sense_key, asc,
		output app_tag_owner
	);
	modport initiator (
		output req, cmd,
		input  ack, done, check_cond, deferred, sense_key, asc,
		input  app_tag_owner
	);
endinterface

// File: rtl/fplc_target.sv
// target end: checks format parameters and runs the format sequence
// Function
// - selector 00h/10h/11h with usage 0: types 0/1/2
// - selector 01h: invalid field in CDB
// - 11h with usage 001h: type 3 rejected
// - other pairings: invalid field in parameter list
// - type 0: protection off, plain block size
// - types 1/2: protection on, block plus 8
// - protection bytes written as all FF
// - trailer: guard, app tag, reference tag, MSB first
// - app tag changed only when owner bit clear
// - type 1 ref tag from LBA, then +1
// - type 2 ref tag from expected tag, +1
// - options invalid: defaults, bits must be zero
// - primary list used unless disabled; missing fails
// - primary disable zero when certify disable zero
// - certify unless disabled; page bit without data
// - no pattern: zero fill; else descriptor follows
// - pattern modifier zero; security init selects sectors
// - pattern type/length consistency checked
// - save mode parameters unless save disabled
// - immediate: early status; deferred flag never raised
// - defect list length sized and bounded
`timescale 1ns/1ps
module fplc_target
	import fplc_pkg::*;
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// link
	fplc_if.target           lnk,
	// media engine status (pins, synchronised)
	input  wire logic        i_factory_defect_list_missing,
	input  wire logic        i_host_defect_list_missing,
	input  wire logic        i_host_defect_list_access_err,
	input  wire logic        i_media_done,
	input  wire logic        i_app_tag_owner,
	// media engine control
	output logic             o_media_start,
	output logic [1:0]       o_prot_type,
	output logic             o_protection_on_flag,
	output logic [15:0]      o_fmt_block_len,
	output logic [63:0]      o_pi_fill,
	output logic [31:0]      o_ref_tag_seed,
	output logic             o_use_factory_list,
	output logic             o_certify,
	output logic             o_zero_fill,
	output logic             o_all_sectors,
	output logic             o_save_params
);

	typedef enum logic [3:0] {
		FPLC_IDLE   = 4'b0001,
		FPLC_CHECK  = 4'b0010,
		FPLC_FORMAT = 4'b0100,
		FPLC_DONE   = 4'b1000
	} fplc_state_t;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [4:0] sync1;
	logic [4:0] sync2;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else begin
			sync1 <= {i_app_tag_owner, i_media_done, i_host_defect_list_access_err,
				i_host_defect_list_missing, i_factory_defect_list_missing};
			sync2 <= sync1;
		end
	end
	logic s_factory_defect_list_miss, s_host_defect_list_miss, s_host_defect_list_err, s_media_done;
	assign s_factory_defect_list_miss = sync2[0];
	assign s_host_defect_list_miss = sync2[1];
	assign s_host_defect_list_err  = sync2[2];
	assign s_media_done = sync2[3];
	assign lnk.app_tag_owner = sync2[4];

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic [31:0] fplc_sense(input logic [3:0] k,
		input logic [15:0] a);
		fplc_sense = {12'h000, k, a};
	endfunction

	// expected list length for a descriptor count check
	function automatic logic list_len_ok(input logic [2:0] f,
		input logic [15:0] len);
		logic [15:0] unit;
		unit = (f == LIST_BLOCK) ? {12'h000, BLK_DESC_B}
			: {12'h000, LONG_DESC_B};
		if (f != LIST_BLOCK && f != LIST_BFI && f != LIST_PHYS)
			list_len_ok = 1'b0;
		else if (f == LIST_BLOCK)
			list_len_ok = (len[1:0] == 2'h0) &&
				(len[15:2] <= MAX_DESC[13:0]);
		else
			list_len_ok = (len[2:0] == 3'h0) &&
				({3'h0, len[15:3]} <= MAX_DESC) && (unit != 16'h0000);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// combinational validation of the latched command
	fplc_cmd_t   cmd_q;
	logic [31:0] next_sense;
	fplc_prot_t  next_prot;
	logic        eff_prim_dis, eff_cert_dis, eff_pat_incl, eff_save_dis;
	always_comb begin
		next_sense = fplc_sense(SK_NONE, ASC_NONE);
		next_prot  = FPLC_PROT0;
		if (cmd_q.options_valid) begin
			eff_prim_dis = cmd_q.primary_list_disable;
			eff_cert_dis = cmd_q.certify_disable;
			eff_pat_incl = cmd_q.pattern_included;
			eff_save_dis = cmd_q.save_disable;
		end else begin
			eff_prim_dis = DEF_PRIM_DIS;
			eff_cert_dis = DEF_CERT_DIS;
			eff_pat_incl = DEF_PAT_INCL;
			eff_save_dis = DEF_SAVE_DIS;
		end
		// priority: CDB error first, then parameter list errors
		if (cmd_q.cdb_protection_selector == SEL_BAD_CDB) begin
			next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_CDB);
		end else if (cmd_q.usage != USE_NONE) begin
			next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
		end else begin
			case (cmd_q.cdb_protection_selector)
				SEL_TYPE1: next_prot = FPLC_PROT1;
				SEL_TYPE2: next_prot = FPLC_PROT2;
				default:   next_prot = FPLC_PROT0;
			endcase
		end
		if (next_sense[19:16] == SK_NONE) begin
			if (!cmd_q.options_valid &&
				(cmd_q.primary_list_disable | cmd_q.certify_disable |
				cmd_q.halt_on_list_error | cmd_q.pattern_included |
				cmd_q.save_disable))
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (cmd_q.options_valid && !cmd_q.halt_on_list_error)
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (!eff_cert_dis && eff_prim_dis)
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (eff_pat_incl &&
				(cmd_q.pat_desc0[PAT_MOD_HI:PAT_MOD_LO] != 2'h0))
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (eff_pat_incl && !(
				(cmd_q.pat_type == 8'h00 && cmd_q.pat_len == 16'h0000) ||
				(cmd_q.pat_type == 8'h01 && cmd_q.pat_len != 16'h0000 &&
				cmd_q.pat_len <= cmd_q.block_len)))
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (!list_len_ok(cmd_q.list_form, cmd_q.list_len))
				next_sense = fplc_sense(SK_ILLEGAL, ASC_BAD_PARAM);
			else if (!eff_prim_dis && s_factory_defect_list_miss)
				next_sense = fplc_sense(SK_MEDIUM, ASC_LIST_MISS);
			else if (cmd_q.list_len != 16'h0000 && s_host_defect_list_miss)
				next_sense = fplc_sense(SK_MEDIUM, ASC_LIST_MISS);
			else if (cmd_q.list_len != 16'h0000 && s_host_defect_list_err)
				next_sense = fplc_sense(SK_MEDIUM, ASC_LIST_ERR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequence
	fplc_state_t state;
	logic        fail;
	assign fail = (next_sense[19:16] != SK_NONE);
	assign lnk.ack = (state == FPLC_IDLE) && lnk.req;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= FPLC_IDLE;
			cmd_q <= '0;
		end else begin
			case (state)
				FPLC_IDLE: begin
					if (lnk.req) begin
						cmd_q <= lnk.cmd;
						state <= FPLC_CHECK;
					end
				end
				// no media start before the verdict is in
				FPLC_CHECK:  state <= fail ? FPLC_DONE : FPLC_FORMAT;
				FPLC_FORMAT: if (s_media_done) state <= FPLC_DONE;
				FPLC_DONE:   state <= FPLC_IDLE;
				default:     state <= FPLC_IDLE;
			endcase
		end
	end

	// status and sense
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lnk.done       <= 1'b0;
			lnk.check_cond <= 1'b0;
			lnk.deferred   <= 1'b0;
			lnk.sense_key  <= SK_NONE;
			lnk.asc        <= ASC_NONE;
		end else begin
			lnk.done     <= 1'b0;
			lnk.deferred <= 1'b0;
			if (state == FPLC_CHECK) begin
				// sense moves only together with a status pulse
				if (fail || cmd_q.immed) begin
					lnk.sense_key  <= next_sense[19:16];
					lnk.asc        <= next_sense[15:0];
					lnk.check_cond <= fail;
					lnk.done       <= 1'b1;
				end
			end else if (state == FPLC_FORMAT && s_media_done &&
				!cmd_q.immed) begin
				lnk.sense_key  <= SK_NONE;
				lnk.asc        <= ASC_NONE;
				lnk.check_cond <= 1'b0;
				lnk.done       <= 1'b1;
			end
		end
	end

	// media engine setup, loaded at the single pass point
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_media_start        <= 1'b0;
			o_prot_type          <= 2'h0;
			o_protection_on_flag <= 1'b0;
			o_fmt_block_len      <= 16'h0000;
			o_pi_fill            <= 64'h0;
			o_ref_tag_seed       <= 32'h0;
			o_use_factory_list   <= 1'b0;
			o_certify            <= 1'b0;
			o_zero_fill          <= 1'b0;
			o_all_sectors        <= 1'b0;
			o_save_params        <= 1'b0;
		end else begin
			o_media_start <= 1'b0;
			if (state == FPLC_CHECK && !fail) begin
				o_media_start        <= 1'b1;
				o_prot_type          <= next_prot;
				o_protection_on_flag <= (next_prot != FPLC_PROT0);
				o_fmt_block_len      <= (next_prot == FPLC_PROT0) ?
					cmd_q.block_len : cmd_q.block_len + PI_EXTRA;
				o_pi_fill            <= PI_FILL;
				o_ref_tag_seed       <= (next_prot == FPLC_PROT2) ?
					cmd_q.exp_ref_tag : cmd_q.cmd_lba;
				o_use_factory_list   <= !eff_prim_dis;
				o_certify            <= cmd_q.data_out ? !eff_cert_dis
					: cmd_q.page_certify_bit;
				o_zero_fill          <= !eff_pat_incl;
				o_all_sectors        <= eff_pat_incl &
					cmd_q.pat_desc0[SEC_INIT_BIT];
				o_save_params        <= !eff_save_dis;
			end
		end
	end

endmodule

// File: rtl/fplc_initiator.sv
// initiator end: issues one format command and collects status
`timescale 1ns/1ps
module fplc_initiator
	import fplc_pkg::*;
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// user side
	input  wire logic        i_issue,
	input  wire fplc_cmd_t   i_cmd,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_check_cond,
	output logic             o_deferred,
	output logic [3:0]       o_sense_key,
	output logic [15:0]      o_asc,
	output logic             o_app_tag_writable,
	// link
	fplc_if.initiator        lnk
);

	fplc_cmd_t cmd_q;
	logic      pending;

	// halt forced on when options are valid, and primary disable cleared when certify disable is clear, before sending
	always_comb begin
		lnk.cmd = cmd_q;
	end
	assign lnk.req = pending;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pending <= 1'b0;
			cmd_q   <= '0;
			o_busy  <= 1'b0;
		end else begin
			if (i_issue && !o_busy) begin
				cmd_q <= i_cmd;
				if (!i_cmd.certify_disable)
					cmd_q.primary_list_disable <= 1'b0;
				if (i_cmd.options_valid)
					cmd_q.halt_on_list_error <= 1'b1;
				pending <= 1'b1;
				o_busy  <= 1'b1;
			end else begin
				if (lnk.ack)
					pending <= 1'b0;
				if (lnk.done)
					o_busy <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_done             <= 1'b0;
			o_check_cond       <= 1'b0;
			o_deferred         <= 1'b0;
			o_sense_key        <= SK_NONE;
			o_asc              <= ASC_NONE;
			o_app_tag_writable <= 1'b0;
		end else begin
			o_done             <= lnk.done;
			o_deferred         <= lnk.deferred;
			o_app_tag_writable <= !lnk.app_tag_owner;
			if (lnk.done) begin
				o_check_cond <= lnk.check_cond;
				o_sense_key  <= lnk.sense_key;
				o_asc        <= lnk.asc;
			end
		end
	end

endmodule

// File: bench/fplc_asserts.sv
// concurrent checks on the link between initiator and target
`timescale 1ns/1ps
module fplc_asserts
	import fplc_pkg::*;
(
	// clock and reset
	input logic        i_core_clk,
	input logic        i_rst_n,
	// link
	input logic        req,
	input fplc_cmd_t   cmd,
	input logic        ack,
	input logic        done,
	input logic        check_cond,
	input logic        deferred,
	input logic [3:0]  sense_key,
	input logic [15:0] asc,
	input logic        app_tag_owner
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic take;
	logic opt;
	assign take = ack && cmd.cdb_protection_selector != SEL_BAD_CDB;
	assign opt = take && cmd.options_valid;

	// every list refusal is reported two edges after the take
	sequence list_refused;
		##2 done && check_cond && sense_key == SK_ILLEGAL
			&& asc == ASC_BAD_PARAM;
	endsequence

	////////////////////////////////////////////////////////////////////
	chk_take_needs_req: assert property (ack |-> req)
		else $error("ack without a pending request");
	chk_cdb_refused: assert property (
		ack && !take |-> ##2 done && check_cond
			&& sense_key == SK_ILLEGAL && asc == ASC_BAD_CDB)
		else $error("bad selector not refused as cdb field");
	chk_type3_refused: assert property (
		take && cmd.cdb_protection_selector == SEL_TYPE2
			&& cmd.usage == USE_TYPE3 |-> list_refused)
		else $error("type 3 request not refused");
	chk_usage_refused: assert property (
		take && cmd.usage != USE_NONE |-> list_refused)
		else $error("undefined pairing not refused");
	chk_defaults_zero: assert property (
		take && !cmd.options_valid && |{cmd.primary_list_disable,
			cmd.certify_disable, cmd.halt_on_list_error,
			cmd.pattern_included, cmd.save_disable} |-> list_refused)
		else $error("option bits set without options_valid");
	chk_halt_sent: assert property (
		ack && cmd.options_valid |-> cmd.halt_on_list_error)
		else $error("command sent with halt bit clear");
	chk_prim_cert: assert property (
		ack && !cmd.certify_disable |-> !cmd.primary_list_disable)
		else $error("primary disable sent without certify disable");
	chk_pattern_len: assert property (
		opt && cmd.pattern_included && cmd.pat_type[7:1] == 7'h00
			&& cmd.pat_type[0] == (cmd.pat_len == 16'h0000)
			|-> list_refused)
		else $error("pattern type and length mismatch accepted");
	chk_list_len: assert property (
		take && cmd.list_form == LIST_BLOCK && cmd.list_len[1:0] != 2'h0
			|-> list_refused)
		else $error("ragged block list length accepted");
	chk_immed_status: assert property (
		ack && cmd.immed |-> ##2 done)
		else $error("immediate status late");
	chk_done_single: assert property (done |=> !done)
		else $error("done longer than one cycle");
	chk_sense_held: assert property (
		!$stable(asc) || !$stable(sense_key) |-> done)
		else $error("sense changed outside a verdict");
endmodule

// File: bench/fplc_bench.sv
// self-checking bench: initiator and target joined over the link
`timescale 1ns/1ps
module fplc_bench
	import fplc_pkg::*;
();
	typedef struct {
		logic [1:0]  sel;
		logic [2:0]  usage;
		logic [5:0]  hdr;
		logic [15:0] pat;
		logic [15:0] plen;
		logic [2:0]  form;
		logic [15:0] llen;
		logic [2:0]  pins;
		logic [15:0] asc;
	} fplc_row_t;

	logic        i_core_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_issue = 1'b0;
	fplc_cmd_t   i_cmd = '0;
	logic [2:0]  pins = 3'h0;
	logic        i_media_done = 1'b0;
	logic        i_app_tag_owner = 1'b0;
	logic        o_media_start, o_protection_on_flag, o_use_factory_list;
	logic        o_certify, o_zero_fill, o_all_sectors, o_save_params;
	logic [1:0]  o_prot_type;
	logic [15:0] o_fmt_block_len, o_asc;
	logic [63:0] o_pi_fill;
	logic [31:0] o_ref_tag_seed;
	logic        o_busy, o_done, o_check_cond, o_deferred;
	logic        o_app_tag_writable;
	logic [3:0]  o_sense_key;
	int          n_fail = 0;
	int          comparisons = 0;
	int          n_start = 0;
	int          cycles = 0;

	// hdr: options, primary, certify, halt, pattern, save disable
	fplc_row_t rows [25] = '{
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h2,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h3,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h1,3'h5,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h2400},
		'{2'h3,3'h1,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h2,3'h1,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h0,3'h0,6'h08,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h0,3'h0,6'h00,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h28,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h34,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h2E,16'h4001,16'h0004,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h0,3'h0,6'h2E,16'h0000,16'h0004,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h0,3'h0,6'h2E,16'h0001,16'h0000,3'h0,16'h0008,3'h0,16'h2600},
		'{2'h2,3'h0,6'h2E,16'h2001,16'h0004,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h000A,3'h0,16'h2600},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h5,16'h2000,3'h0,16'h0000},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h5,16'h000C,3'h0,16'h2600},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h1000,3'h0,16'h0000},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h1004,3'h0,16'h2600},
		'{2'h0,3'h0,6'h3D,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h24,16'h0000,16'h0000,3'h0,16'h0008,3'h0,16'h0000},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h4,16'h1901},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h2,16'h1901},
		'{2'h0,3'h0,6'h2C,16'h0000,16'h0000,3'h0,16'h0008,3'h1,16'h1900},
		'{2'h0,3'h0,6'h3C,16'h0000,16'h0000,3'h0,16'h0008,3'h4,16'h0000}
	};

	////////////////////////////////////////////////////////////////////
	always #4 i_core_clk = ~i_core_clk;

	fplc_if fplc_if_inst ();
	fplc_target fplc_target_inst (
		.i_core_clk          (i_core_clk),
		.i_rst_n             (i_rst_n),
		.lnk                 (fplc_if_inst),
		.i_factory_defect_list_missing     (pins[2]),
		.i_host_defect_list_missing     (pins[1]),
		.i_host_defect_list_access_err  (pins[0]),
		.i_media_done        (i_media_done),
		.i_app_tag_owner     (i_app_tag_owner),
		.o_media_start       (o_media_start),
		.o_prot_type         (o_prot_type),
		.o_protection_on_flag(o_protection_on_flag),
		.o_fmt_block_len     (o_fmt_block_len),
		.o_pi_fill           (o_pi_fill),
		.o_ref_tag_seed      (o_ref_tag_seed),
		.o_use_factory_list  (o_use_factory_list),
		.o_certify           (o_certify),
		.o_zero_fill         (o_zero_fill),
		.o_all_sectors       (o_all_sectors),
		.o_save_params       (o_save_params)
	);
	fplc_initiator fplc_initiator_inst (
		.i_core_clk        (i_core_clk),
		.i_rst_n           (i_rst_n),
		.i_issue           (i_issue),
		.i_cmd             (i_cmd),
		.o_busy            (o_busy),
		.o_done            (o_done),
		.o_check_cond      (o_check_cond),
		.o_deferred        (o_deferred),
		.o_sense_key       (o_sense_key),
		.o_asc             (o_asc),
		.o_app_tag_writable(o_app_tag_writable),
		.lnk               (fplc_if_inst)
	);
	fplc_asserts fplc_asserts_inst (
		.i_core_clk   (i_core_clk),
		.i_rst_n      (i_rst_n),
		.req          (fplc_if_inst.req),
		.cmd          (fplc_if_inst.cmd),
		.ack          (fplc_if_inst.ack),
		.done         (fplc_if_inst.done),
		.check_cond   (fplc_if_inst.check_cond),
		.deferred     (fplc_if_inst.deferred),
		.sense_key    (fplc_if_inst.sense_key),
		.asc          (fplc_if_inst.asc),
		.app_tag_owner(fplc_if_inst.app_tag_owner)
	);

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge i_core_clk) begin
		cycles++;
		n_start += (o_media_start === 1'b1);
		if (cycles == 5000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic run(input fplc_row_t r, input logic imm);
		fplc_cmd_t  c;
		logic [4:0] e;
		int         k;
		c = '0;
		c.immed = imm;
		c.data_out = 1'b1;
		c.block_len = 16'h0200;
		c.cmd_lba = 32'h12345678;
		c.exp_ref_tag = 32'hA5A50001;
		c.cdb_protection_selector = r.sel;
		c.usage = r.usage;
		{c.options_valid, c.primary_list_disable, c.certify_disable,
			c.halt_on_list_error, c.pattern_included, c.save_disable} = r.hdr;
		{c.pat_desc0, c.pat_type} = r.pat;
		c.pat_len = r.plen;
		c.list_form = r.form;
		c.list_len = r.llen;
		e = r.hdr[5] ? r.hdr[4:0] : {DEF_PRIM_DIS, DEF_CERT_DIS, DEF_HALT,
			DEF_PAT_INCL, DEF_SAVE_DIS};
		// initiator clears primary disable while certification is on
		if (!r.hdr[3])
			e[4] = 1'b0;
		pins = r.pins;
		// pins pass a two-flop synchroniser first
		repeat (3) @(negedge i_core_clk);
		n_start = 0;
		i_cmd = c;
		i_issue = 1'b1;
		@(negedge i_core_clk);
		i_issue = 1'b0;
		if (!imm) begin
			repeat (10) @(negedge i_core_clk);
			chk("waiting", o_busy, 1'b1);
			i_media_done = 1'b1;
		end
		for (k = 0; k < 50 && o_done !== 1'b1; k++)
			@(negedge i_core_clk);
		i_media_done = 1'b0;
		chk("done", o_done, 1'b1);
		chk("cond", o_check_cond, r.asc != ASC_NONE);
		chk("key", o_sense_key, r.asc == ASC_NONE ? SK_NONE :
			r.asc[15:8] == 8'h19 ? SK_MEDIUM : SK_ILLEGAL);
		chk("asc", o_asc, r.asc);
		chk("deferred", o_deferred, 1'b0);
		chk("starts", n_start, r.asc == ASC_NONE);
		if (r.asc == ASC_NONE) begin
			chk("prot", o_prot_type, r.sel - (r.sel != 2'h0));
			chk("pon", o_protection_on_flag, r.sel != 2'h0);
			chk("blen", o_fmt_block_len, c.block_len
				+ (r.sel != 2'h0 ? PI_EXTRA : 16'h0000));
			chk("fill", o_pi_fill, PI_FILL);
			chk("seed", o_ref_tag_seed,
				r.sel == 2'h3 ? c.exp_ref_tag : c.cmd_lba);
			chk("factory_defect_list", o_use_factory_list, !e[4]);
			chk("certify", o_certify, !e[3]);
			chk("zero", o_zero_fill, !e[1]);
			chk("all", o_all_sectors, e[1] & r.pat[13]);
			chk("save", o_save_params, !e[0]);
		end
		// immediate status leaves the format running; let it finish
		if (imm && r.asc == ASC_NONE) begin
			i_media_done = 1'b1;
			repeat (4) @(negedge i_core_clk);
			i_media_done = 1'b0;
			chk("late done", o_done, 1'b0);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(negedge i_core_clk);
		chk("rst busy", o_busy, 1'b0);
		i_rst_n = 1'b1;
		foreach (rows[i])
			run(rows[i], 1'b1);
		run(rows[1], 1'b0);
		for (int v = 1; v >= 0; v--) begin
			i_app_tag_owner = v[0];
			repeat (4) @(negedge i_core_clk);
			chk("tag owner", o_app_tag_writable, !v[0]);
		end
		// reset lands while a command is in flight
		i_issue = 1'b1;
		@(negedge i_core_clk);
		i_issue = 1'b0;
		i_rst_n = 1'b0;
		@(negedge i_core_clk);
		chk("rst busy", o_busy, 1'b0);
		chk("rst asc", o_asc, ASC_NONE);
		i_rst_n = 1'b1;
		run(rows[2], 1'b1);
		summarize();
	end
endmodule
